// File: shared/somsel_pkg.sv
// Package for the startup operating mode selector.
// Assumes a single clock domain and plain-port configuration inputs.
`default_nettype none

package somsel_pkg;

   typedef enum logic [1:0] {
      MODE_TERMINAL,
      MODE_PANEL,
      MODE_COMMS,
      MODE_COMBINED
   } somsel_mode_t;

   localparam logic [3:0] OPSEL_RESET = 4'h0;
   localparam logic [3:0] OPSEL_PANEL_FIXED = 4'h1;
   localparam logic [3:0] OPSEL_NO_PANEL = 4'h2;
   localparam logic [3:0] OPSEL_COMBINED_A = 4'h3;
   localparam logic [3:0] OPSEL_COMBINED_B = 4'h4;
   localparam logic [3:0] OPSEL_RUN_SWITCH = 4'h6;
   localparam logic [3:0] OPSEL_STOP_GATED = 4'h7;

   localparam logic [3:0] STSEL_RESET = 4'h0;
   localparam logic [3:0] STSEL_COMMS = 4'h1;
   localparam logic [3:0] STSEL_PANEL_COMMS = 4'hA;

   localparam logic [3:0] GROUP_READ_OPEN = 4'h0;

endpackage : somsel_pkg

`default_nettype wire

// File: verilog/somsel_allow.sv
// Switching permission table for the operating mode selector.
// Assumes settings already captured; purely combinational.
`default_nettype none

module somsel_allow (
   // Settings
   input wire logic [3:0] opsel_in,
   input wire logic [3:0] stsel_in,
   input wire logic output_stop_input_in,
   // Permissions
   output logic panel_comms_pair_out,
   output logic comms_terminal_pair_out,
   output logic panel_terminal_pair_out,
   output logic run_switch_out,
   output logic force_terminal_out
);

   logic pc_start;

   assign pc_start = (stsel_in == somsel_pkg::STSEL_PANEL_COMMS);

   always_comb begin
      panel_comms_pair_out = 1'b0;
      comms_terminal_pair_out = 1'b0;
      panel_terminal_pair_out = 1'b0;
      run_switch_out = 1'b0;
      force_terminal_out = 1'b0;
      case (opsel_in)
         somsel_pkg::OPSEL_RESET: begin
            if (pc_start) begin
               panel_comms_pair_out = 1'b1;
            end else begin
               comms_terminal_pair_out = 1'b1;
               panel_terminal_pair_out = 1'b1;
            end
         end
         somsel_pkg::OPSEL_NO_PANEL: begin
            comms_terminal_pair_out = !pc_start;
         end
         somsel_pkg::OPSEL_RUN_SWITCH: begin
            run_switch_out = 1'b1;
            if (pc_start) begin
               panel_comms_pair_out = 1'b1;
            end else begin
               comms_terminal_pair_out = 1'b1;
               panel_terminal_pair_out = 1'b1;
            end
         end
         somsel_pkg::OPSEL_STOP_GATED: begin
            if (output_stop_input_in) begin
               comms_terminal_pair_out = 1'b1;
               panel_terminal_pair_out = 1'b1;
            end else begin
               force_terminal_out = 1'b1;
            end
         end
         default: begin
         end
      endcase
   end

endmodule : somsel_allow

`default_nettype wire

// File: verilog/somsel_top.sv
// Startup operating mode selector: start mode, switch requests, settings.
// Assumes all inputs synchronous to ref_clk_in; switch inputs are levels,
// the panel mode key is a one-cycle pulse.
`default_nettype none

module somsel_top (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   // Setting writes
   input wire logic opsel_wr_in,
   input wire logic [3:0] opsel_wdata_in,
   input wire logic stsel_wr_in,
   input wire logic [3:0] stsel_wdata_in,
   input wire logic [3:0] user_group_read_selection_in,
   input wire logic comms_option_connected_in,
   // Drive state
   input wire logic motor_running_in,
   input wire logic start_command_in,
   // Switching inputs
   input wire logic output_stop_input_in,
   input wire logic comms_terminal_switch_input_in,
   input wire logic comms_terminal_assigned_in,
   input wire logic panel_comms_switch_input_in,
   input wire logic panel_comms_assigned_in,
   input wire logic panel_terminal_switch_input_in,
   input wire logic panel_terminal_assigned_in,
   input wire logic panel_mode_key_in,
   // Status
   output logic [1:0] mode_out,
   output logic [3:0] operating_mode_selection_out,
   output logic [3:0] startup_mode_selection_out,
   output logic write_rejected_out
);

   // ----------------------------------------------------------------
   // Settings
   // ----------------------------------------------------------------

   logic [3:0] opsel;
   logic [3:0] stsel;
   logic stopped;
   logic stsel_ok;
   logic init_pending;
   logic opsel_take;
   logic stsel_take;
   logic opsel_refuse;
   logic stsel_refuse;

   assign stopped = !motor_running_in || !start_command_in;
   assign stsel_ok = (user_group_read_selection_in ==
                      somsel_pkg::GROUP_READ_OPEN) ||
                     comms_option_connected_in;

   // A refused write leaves the setting as it was and raises the reject
   // flag for one cycle, so a write made while running is visible.
   assign opsel_take = opsel_wr_in && stopped;
   assign stsel_take = stsel_wr_in && stopped && stsel_ok;
   assign opsel_refuse = opsel_wr_in && !opsel_take;
   assign stsel_refuse = stsel_wr_in && !stsel_take;

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         opsel <= somsel_pkg::OPSEL_RESET;
      end else if (opsel_take) begin
         opsel <= opsel_wdata_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stsel <= somsel_pkg::STSEL_RESET;
      end else if (stsel_take) begin
         stsel <= stsel_wdata_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         write_rejected_out <= 1'b0;
      end else begin
         write_rejected_out <= opsel_refuse || stsel_refuse;
      end
   end

   // ----------------------------------------------------------------
   // Permissions
   // ----------------------------------------------------------------

   logic pc_pair;
   logic ct_pair;
   logic pt_pair;
   logic run_switch;
   logic force_terminal;

   somsel_allow u_allow (
      .opsel_in(opsel),
      .stsel_in(stsel),
      .output_stop_input_in(output_stop_input_in),
      .panel_comms_pair_out(pc_pair),
      .comms_terminal_pair_out(ct_pair),
      .panel_terminal_pair_out(pt_pair),
      .run_switch_out(run_switch),
      .force_terminal_out(force_terminal)
   );

   // ----------------------------------------------------------------
   // Startup setting decode
   // ----------------------------------------------------------------

   // Startup setting 1 asks for comms on every selection that can run
   // in comms; setting 10 does so on selections 0, 2 and 6 but not on selection 7.
   logic st_comms;
   logic st_pair;

   assign st_comms = (stsel == somsel_pkg::STSEL_COMMS);
   assign st_pair = (stsel == somsel_pkg::STSEL_PANEL_COMMS);

   // ----------------------------------------------------------------
   // Startup mode
   // ----------------------------------------------------------------

   // Fixed panel and combined selections ignore the startup setting,
   // which only steers the selections that can reach comms.
   somsel_pkg::somsel_mode_t start_mode;

   always_comb begin
      start_mode = somsel_pkg::MODE_TERMINAL;
      case (opsel)
         somsel_pkg::OPSEL_PANEL_FIXED: begin
            start_mode = somsel_pkg::MODE_PANEL;
         end
         somsel_pkg::OPSEL_COMBINED_A, somsel_pkg::OPSEL_COMBINED_B: begin
            start_mode = somsel_pkg::MODE_COMBINED;
         end
         somsel_pkg::OPSEL_RESET, somsel_pkg::OPSEL_NO_PANEL,
         somsel_pkg::OPSEL_RUN_SWITCH: begin
            if (st_comms || st_pair) begin
               start_mode = somsel_pkg::MODE_COMMS;
            end
         end
         somsel_pkg::OPSEL_STOP_GATED: begin
            // Startup setting 10 falls back to terminal here.
            if (st_comms && output_stop_input_in) begin
               start_mode = somsel_pkg::MODE_COMMS;
            end
         end
         default: begin
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Switch permission while running
   // ----------------------------------------------------------------

   somsel_pkg::somsel_mode_t mode;
   somsel_pkg::somsel_mode_t next_mode;
   logic can_switch;

   // Under selection 6 switching proceeds with the motor running.
   assign can_switch = stopped || run_switch;

   // ----------------------------------------------------------------
   // Stop input
   // ----------------------------------------------------------------

   logic stop_claim;
   somsel_pkg::somsel_mode_t stop_mode;

   // Selection 7 with the stop input off pins terminal mode above every
   // switch input.
   assign stop_claim = force_terminal;
   assign stop_mode = somsel_pkg::MODE_TERMINAL;

   // ----------------------------------------------------------------
   // Comms/terminal input
   // ----------------------------------------------------------------

   // Each source says whether it claims the mode this cycle and which
   // mode it asks for; a claim that cannot move holds the mode, so a
   // weaker source never overrides a stronger one that refused.
   logic ct_claim;
   somsel_pkg::somsel_mode_t ct_mode;

   always_comb begin
      ct_claim = ct_pair && comms_terminal_assigned_in;
      ct_mode = mode;
      if (comms_terminal_switch_input_in) begin
         // Panel to comms directly is never a legal step on this input.
         if (can_switch && mode != somsel_pkg::MODE_PANEL) begin
            ct_mode = somsel_pkg::MODE_COMMS;
         end
      end else if (pt_pair && panel_terminal_assigned_in &&
                   !panel_terminal_switch_input_in &&
                   mode != somsel_pkg::MODE_COMMS) begin
         ct_mode = somsel_pkg::MODE_PANEL;
      end else begin
         ct_mode = somsel_pkg::MODE_TERMINAL;
      end
   end

   // ----------------------------------------------------------------
   // Panel/comms input
   // ----------------------------------------------------------------

   logic pc_claim;
   somsel_pkg::somsel_mode_t pc_mode;

   // Both moves wait for a stop unless selection 6 lets the motor run.
   always_comb begin
      pc_claim = pc_pair && panel_comms_assigned_in;
      pc_mode = mode;
      if (can_switch) begin
         if (panel_comms_switch_input_in) begin
            pc_mode = somsel_pkg::MODE_PANEL;
         end else begin
            pc_mode = somsel_pkg::MODE_COMMS;
         end
      end
   end

   // ----------------------------------------------------------------
   // Panel mode key
   // ----------------------------------------------------------------

   logic key_claim;
   somsel_pkg::somsel_mode_t key_mode;

   always_comb begin
      key_claim = pc_pair && panel_mode_key_in && can_switch;
      key_mode = mode;
      // The key toggles, so it only acts between the two pair modes.
      if (mode == somsel_pkg::MODE_PANEL) begin
         key_mode = somsel_pkg::MODE_COMMS;
      end else if (mode == somsel_pkg::MODE_COMMS) begin
         key_mode = somsel_pkg::MODE_PANEL;
      end
   end

   // ----------------------------------------------------------------
   // Panel/terminal input
   // ----------------------------------------------------------------

   logic pt_claim;
   somsel_pkg::somsel_mode_t pt_mode;

   always_comb begin
      pt_claim = pt_pair && panel_terminal_assigned_in;
      pt_mode = mode;
      // Panel and comms are never swapped directly on this path.
      if (mode != somsel_pkg::MODE_COMMS) begin
         pt_mode = panel_terminal_switch_input_in ?
                   somsel_pkg::MODE_TERMINAL :
                   somsel_pkg::MODE_PANEL;
      end
   end

   // ----------------------------------------------------------------
   // Priority resolution, strongest first
   // ----------------------------------------------------------------

   // The startup setting has the lowest weight: it only acts through
   // the start mode and the pair permissions.
   always_comb begin
      next_mode = mode;
      if (stop_claim) begin
         next_mode = stop_mode;
      end else if (ct_claim) begin
         next_mode = ct_mode;
      end else if (pc_claim) begin
         next_mode = pc_mode;
      end else if (key_claim) begin
         next_mode = key_mode;
      end else if (pt_claim) begin
         next_mode = pt_mode;
      end
   end

   // ----------------------------------------------------------------
   // Init edge
   // ----------------------------------------------------------------

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         init_pending <= 1'b1;
      end else begin
         init_pending <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Held mode
   // ----------------------------------------------------------------

   // The first edge after release loads the startup mode, so the stop
   // input is sampled by the clock rather than by the reset itself.
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mode <= somsel_pkg::MODE_TERMINAL;
      end else if (init_pending) begin
         mode <= start_mode;
      end else begin
         mode <= next_mode;
      end
   end

   // ----------------------------------------------------------------
   // Status
   // ----------------------------------------------------------------

   // Mode and settings come straight from their flip-flops, so every
   // consumer sees one consistent mode.
   assign mode_out = mode;
   assign operating_mode_selection_out = opsel;
   assign startup_mode_selection_out = stsel;

endmodule : somsel_top

`default_nettype wire

// File: test/somsel_checker.sv
// Port-level assertions for the startup operating mode selector.
// Assumes binding to somsel_top with one clock domain.
`default_nettype none

module somsel_checker (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   // Inputs
   input wire logic opsel_wr_in,
   input wire logic [3:0] opsel_wdata_in,
   input wire logic stsel_wr_in,
   input wire logic [3:0] stsel_wdata_in,
   input wire logic [3:0] user_group_read_selection_in,
   input wire logic comms_option_connected_in,
   input wire logic motor_running_in,
   input wire logic start_command_in,
   input wire logic output_stop_input_in,
   // Outputs
   input wire logic [1:0] mode_out,
   input wire logic [3:0] operating_mode_selection_out,
   input wire logic [3:0] startup_mode_selection_out,
   input wire logic write_rejected_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   logic run;
   logic perm;
   logic [3:0] sel;
   assign run = motor_running_in && start_command_in;
   assign sel = operating_mode_selection_out;
   assign perm = user_group_read_selection_in == 4'h0 ||
      comms_option_connected_in;
   a_reset_start: assert property ($rose(rst_b_in) |-> mode_out == 2'h0
      && sel == 4'h0) else $error("start state wrong");
   a_op_taken: assert property (opsel_wr_in && !run |=>
      sel == $past(opsel_wdata_in)) else $error("selection write lost");
   a_op_refused: assert property (opsel_wr_in && run |=>
      write_rejected_out && $stable(sel)) else $error("running write kept");
   a_st_taken: assert property (stsel_wr_in && !run && perm |=>
      startup_mode_selection_out == $past(stsel_wdata_in))
      else $error("startup write lost");
   a_st_refused: assert property (stsel_wr_in && !perm |=>
      write_rejected_out && $stable(startup_mode_selection_out))
      else $error("startup write kept");
   a_no_direct: assert property (mode_out == 2'h1 &&
      startup_mode_selection_out == 4'h0 |=> mode_out != 2'h2)
      else $error("panel to comms");
   a_sel2_panel: assert property (sel == 4'h2 && mode_out != 2'h1 &&
      !opsel_wr_in |=> mode_out != 2'h1) else $error("panel under sel 2");
   a_sel7_force: assert property (sel == 4'h7 && !output_stop_input_in
      && !opsel_wr_in |=> mode_out == 2'h0) else $error("sel 7 not forced");
   a_run_comms: assert property (run && mode_out != 2'h2 && sel != 4'h6
      && !opsel_wr_in && $past(rst_b_in) |=> mode_out != 2'h2)
      else $error("comms while running");
   c_comms: cover property (mode_out == 2'h2);
   c_panel: cover property (mode_out == 2'h1);
   c_reject: cover property (write_rejected_out);
endmodule : somsel_checker

`default_nettype wire

// File: test/somsel_top_test.sv
// Self-checking bench for the startup operating mode selector.
// Assumes the design's reset clears both settings to zero.
`default_nettype none

module somsel_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   // -----------------------------------------------------------------
   // Stimulus and checks
   // -----------------------------------------------------------------
   logic ref_clk_in = 0, rst_b_in = 0, opsel_wr_in = 0, stsel_wr_in = 0;
   logic [3:0] opsel_wdata_in = 0, stsel_wdata_in = 0;
   logic [3:0] user_group_read_selection_in = 0;
   logic comms_option_connected_in = 0, motor_running_in = 0;
   logic start_command_in = 0, output_stop_input_in = 0;
   logic comms_terminal_switch_input_in = 0, comms_terminal_assigned_in = 0;
   logic panel_comms_switch_input_in = 0, panel_comms_assigned_in = 0;
   logic panel_terminal_switch_input_in = 0;
   logic panel_terminal_assigned_in = 0, panel_mode_key_in = 0;
   logic [1:0] mode_out;
   logic [3:0] operating_mode_selection_out, startup_mode_selection_out;
   logic write_rejected_out;
   int failures = 0, num_checks = 0, i;
   integer seed = 32'h7959;
   somsel_top i_dut (.*);
   always #2.5 ref_clk_in = ~ref_clk_in;
   task automatic chk(input string n, input logic [3:0] e, g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask : tick
   task automatic wr(input bit st, input logic [3:0] v);
      @(posedge ref_clk_in);
      if (st) stsel_wr_in <= 1'b1;
      else opsel_wr_in <= 1'b1;
      stsel_wdata_in <= v;
      opsel_wdata_in <= v;
      @(posedge ref_clk_in);
      stsel_wr_in <= 1'b0;
      opsel_wr_in <= 1'b0;
      #1;
   endtask : wr
   // Stopped may also mean running with the start command off.
   task automatic run(input logic r);
      @(posedge ref_clk_in);
      motor_running_in <= r | 1'($random(seed));
      start_command_in <= r;
   endtask : run
   task automatic ct(input logic v);
      @(posedge ref_clk_in);
      comms_terminal_switch_input_in <= v;
      tick(2);
   endtask : ct
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   // The run is under a hundred cycles, so 20 us only trips on a hang.
   initial begin
      #20000;
      failures++;
      close_out();
   end
   initial begin
      repeat (4) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      tick(2);
      chk("mode", 4'h0, mode_out);
      chk("opsel", 4'h0, operating_mode_selection_out);
      $display("test reset done");
      comms_terminal_assigned_in <= 1'b1;
      ct(1);
      chk("mode", 4'h2, mode_out);
      ct(0);
      chk("mode", 4'h0, mode_out);
      run(1);
      ct(1);
      chk("mode", 4'h0, mode_out);
      for (i = 0; i < 3; i++) begin
         wr(0, 4'($random(seed)));
         chk("rej", 4'h1, write_rejected_out);
         chk("opsel", 4'h0, operating_mode_selection_out);
      end
      wr(1, 4'h1);
      chk("stsel", 4'h0, startup_mode_selection_out);
      ct(0);
      run(0);
      wr(0, 4'h6);
      chk("opsel", 4'h6, operating_mode_selection_out);
      run(1);
      ct(1);
      chk("mode", 4'h2, mode_out);
      ct(0);
      run(0);
      $display("test running done");
      wr(0, 4'h7);
      ct(1);
      chk("mode", 4'h0, mode_out);
      @(posedge ref_clk_in);
      output_stop_input_in <= 1'b1;
      tick(2);
      chk("mode", 4'h2, mode_out);
      @(posedge ref_clk_in);
      rst_b_in <= 1'b0;
      comms_terminal_assigned_in <= 1'b0;
      tick(2);
      @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      tick(2);
      chk("mode", 4'h0, mode_out);
      chk("opsel", 4'h0, operating_mode_selection_out);
      $display("test sel 7 done");
      wr(0, 4'h2);
      @(posedge ref_clk_in);
      panel_terminal_assigned_in <= 1'b1;
      tick(2);
      chk("mode", 4'h0, mode_out);
      wr(0, 4'h0);
      tick(1);
      chk("mode", 4'h1, mode_out);
      @(posedge ref_clk_in);
      comms_terminal_assigned_in <= 1'b1;
      tick(2);
      chk("mode", 4'h1, mode_out);
      @(posedge ref_clk_in);
      comms_terminal_assigned_in <= 1'b0;
      panel_terminal_switch_input_in <= 1'b1;
      tick(2);
      chk("mode", 4'h0, mode_out);
      $display("test panel done");
      @(posedge ref_clk_in);
      user_group_read_selection_in <= 4'h3;
      wr(1, 4'h1);
      chk("rej", 4'h1, write_rejected_out);
      chk("stsel", 4'h0, startup_mode_selection_out);
      @(posedge ref_clk_in);
      comms_option_connected_in <= 1'b1;
      wr(1, 4'hA);
      chk("stsel", 4'hA, startup_mode_selection_out);
      @(posedge ref_clk_in);
      panel_comms_assigned_in <= 1'b1;
      tick(2);
      chk("mode", 4'h2, mode_out);
      @(posedge ref_clk_in);
      panel_comms_switch_input_in <= 1'b1;
      tick(2);
      chk("mode", 4'h1, mode_out);
      @(posedge ref_clk_in);
      panel_comms_assigned_in <= 1'b0;
      panel_mode_key_in <= 1'b1;
      @(posedge ref_clk_in);
      panel_mode_key_in <= 1'b0;
      tick(1);
      chk("mode", 4'h2, mode_out);
      @(posedge ref_clk_in);
      comms_option_connected_in <= 1'b0;
      user_group_read_selection_in <= 4'h0;
      wr(1, 4'h1);
      chk("stsel", 4'h1, startup_mode_selection_out);
      $display("test startup write done");
      close_out();
   end
endmodule : somsel_top_test

bind somsel_top somsel_checker i_chk (.*);

`default_nettype wire
